// ---- logic/pcwl_loader.sv ----
// pcwl_loader: maps loaded configuration words onto per-port register fields.
// assumes: a word source presents address and data with a one-cycle valid,
// and LOAD_END marks the end of the load; registers are 32-bit images.
`timescale 1ns/1ns
//
// Contract
// - port 2 word bits 6:4 give logical port number
// - port 2 word bits 15:9 give vc0 map
// - power budget words at 70h, 72h, 74h
// - base power and data scale to 214h low bits
// - pm state bits 11:10 to 214h bits 14:13
// - bit 15 to 218h bit 0
// - pm control words 80h-84h to 74h bits 13:8
// - pm fields: d3-l1, l1 delay, l0s enable
// - bit 6 to 74h bit 14, rx polarity
// - bit 7 to 70h bit 31, vga decode
// - bits 15:8 to 88h bits 31:24
// - word 92h to port 1 d4h low half
module pcwl_loader
    import pcwl_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic WORD_VALID,
    input wire logic [7:0] WORD_ADDR,
    input wire logic [15:0] WORD_DATA,
    input wire logic LOAD_END,
    output logic CFG_READY,
    output logic [31:0] P2_PORTNUM_REG,
    output logic [31:0] P2_VC0MAP_REG,
    output logic [95:0] PWR_BUDGET0_REGS,
    output logic [95:0] PWR_BUDGET1_REGS,
    output logic [95:0] PM_CONTROL_REGS,
    output logic [95:0] VGA_DECODE_REGS,
    output logic [95:0] PHY_PIPE_CONTROL_FIVE_REGS,
    output logic [31:0] P1_SLOTCAP_REG
);

    // load map handled by this block:
    //   64h  port 2 logical number and vc0 map
    //        data 6:4   -> CCh bits 26:24
    //        data 15:9  -> 154h bits 7:1
    //   70h  port 0 power budget
    //   72h  port 1 power budget
    //   74h  port 2 power budget
    //        data 7:0   -> 214h bits 7:0
    //        data 9:8   -> 214h bits 9:8
    //        data 11:10 -> 214h bits 14:13
    //        data 15    -> 218h bit 0
    //   80h  port 0 power control
    //   82h  port 1 power control
    //   84h  port 2 power control
    //        data 5:0   -> 74h bits 13:8
    //        data 6     -> 74h bit 14
    //        data 7     -> 70h bit 31
    //        data 15:8  -> 88h bits 31:24
    //   92h  port 1 slot capability low word
    //        data 15:0  -> D4h bits 15:0
    // any other address is dropped without effect;
    // bits of an image not listed stay zero.
    //
    // reset defaults:
    //   logical port number 2, vc0 map all ones,
    //   every other loaded field zero
    // timing:
    //   a taken word shows on the outputs one edge later;
    //   the last word sent to an address wins;
    //   readiness rises one edge after the end marker

    // loader state
    pcwl_state_t state_reg;
    // next state from the sequencing logic
    pcwl_state_t state_next;

    // a word counts only while the load is open;
    // after the end marker every word is dropped
    wire logic take = WORD_VALID && (state_reg != PCWL_DONE);

    // address decodes, one strobe per loaded word address
    // port 2 number and vc0 map share one word
    wire logic hit_p2 = take && (WORD_ADDR == WA_PORTNUM_P2);
    // port 1 slot capability low word strobe
    wire logic hit_slot = take && (WORD_ADDR == WA_SLOTLO_P1);
    // power budget strobes, bit n for port n
    wire logic [2:0] hit_pwr;
    // power control strobes, bit n for port n
    wire logic [2:0] hit_pmc;

    // power budget words, ports 0 to 2
    assign hit_pwr[0] = take && (WORD_ADDR == WA_PWR_P0);
    assign hit_pwr[1] = take && (WORD_ADDR == WA_PWR_P1);
    assign hit_pwr[2] = take && (WORD_ADDR == WA_PWR_P2);

    // power control words, ports 0 to 2
    assign hit_pmc[0] = take && (WORD_ADDR == WA_PMC_P0);
    assign hit_pmc[1] = take && (WORD_ADDR == WA_PMC_P1);
    assign hit_pmc[2] = take && (WORD_ADDR == WA_PMC_P2);

    // field outputs of the shared, non per-port words
    // logical port number of port 2
    wire logic [2:0] portnum;
    // vc0 traffic class map of port 2
    wire logic [6:0] vc0map;
    // low word of port 1 slot capability
    wire logic [15:0] slotlo;

    // port 2 logical port number
    pcwl_field_reg #(.W(3), .INIT(RST_PORTNUM)) u_portnum
    (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .load(hit_p2),
        .din(WORD_DATA[6:4]),
        .q(portnum)
    );

    // port 2 vc0 traffic class map
    // loaded by the same word as the port number
    pcwl_field_reg #(.W(7), .INIT(RST_VC0MAP)) u_vc0map
    (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .load(hit_p2),
        .din(WORD_DATA[15:9]),
        .q(vc0map)
    );

    // port 1 slot capability low word
    // the high half lives in another word, not handled here
    pcwl_field_reg #(.W(16), .INIT(RST_SLOTLO)) u_slot
    (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .load(hit_slot),
        .din(WORD_DATA),
        .q(slotlo)
    );

    // per-port field banks, one bank instance per port;
    // each bank sees the shared word and only its own strobes,
    // and its images are packed into a 32-bit slice per port
    // (port n at bits n*32+31 down to n*32)

    // port 0 field bank
    wire logic [14:0] p0_pwr_lo;
    wire logic p0_sys_alloc;
    wire logic [6:0] p0_pm_ctl;
    wire logic p0_vga;
    wire logic [7:0] p0_phy;
    pcwl_port_fields u_fields_p0
    (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .pwr_load(hit_pwr[0]),
        .pmc_load(hit_pmc[0]),
        .word(WORD_DATA),
        .pwr_budget_lo(p0_pwr_lo),
        .pwr_sys_alloc(p0_sys_alloc),
        .pm_control(p0_pm_ctl),
        .vga_enable(p0_vga),
        .phy_pipe_control_five(p0_phy)
    );

    // 214h image: base power, scale, pm state at 14:13
    assign PWR_BUDGET0_REGS[31:0] = {17'h0_0000, p0_pwr_lo};
    // 218h image: system allocated at bit 0
    assign PWR_BUDGET1_REGS[31:0] = {31'h0000_0000, p0_sys_alloc};
    // 74h image: pm fields 13:8, rx polarity disable at 14
    assign PM_CONTROL_REGS[31:0] = {17'h0_0000, p0_pm_ctl, 8'h00};
    // 70h image: vga decode at 31
    assign VGA_DECODE_REGS[31:0] = {p0_vga, 31'h0000_0000};
    // 88h image: phy byte at 31:24
    assign PHY_PIPE_CONTROL_FIVE_REGS[31:0] = {p0_phy, 24'h00_0000};

    // port 1 field bank
    wire logic [14:0] p1_pwr_lo;
    wire logic p1_sys_alloc;
    wire logic [6:0] p1_pm_ctl;
    wire logic p1_vga;
    wire logic [7:0] p1_phy;
    pcwl_port_fields u_fields_p1
    (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .pwr_load(hit_pwr[1]),
        .pmc_load(hit_pmc[1]),
        .word(WORD_DATA),
        .pwr_budget_lo(p1_pwr_lo),
        .pwr_sys_alloc(p1_sys_alloc),
        .pm_control(p1_pm_ctl),
        .vga_enable(p1_vga),
        .phy_pipe_control_five(p1_phy)
    );

    // 214h image: base power, scale, pm state at 14:13
    assign PWR_BUDGET0_REGS[63:32] = {17'h0_0000, p1_pwr_lo};
    // 218h image: system allocated at bit 0
    assign PWR_BUDGET1_REGS[63:32] = {31'h0000_0000, p1_sys_alloc};
    // 74h image: pm fields 13:8, rx polarity disable at 14
    assign PM_CONTROL_REGS[63:32] = {17'h0_0000, p1_pm_ctl, 8'h00};
    // 70h image: vga decode at 31
    assign VGA_DECODE_REGS[63:32] = {p1_vga, 31'h0000_0000};
    // 88h image: phy byte at 31:24
    assign PHY_PIPE_CONTROL_FIVE_REGS[63:32] = {p1_phy, 24'h00_0000};

    // port 2 field bank
    wire logic [14:0] p2_pwr_lo;
    wire logic p2_sys_alloc;
    wire logic [6:0] p2_pm_ctl;
    wire logic p2_vga;
    wire logic [7:0] p2_phy;
    pcwl_port_fields u_fields_p2
    (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .pwr_load(hit_pwr[2]),
        .pmc_load(hit_pmc[2]),
        .word(WORD_DATA),
        .pwr_budget_lo(p2_pwr_lo),
        .pwr_sys_alloc(p2_sys_alloc),
        .pm_control(p2_pm_ctl),
        .vga_enable(p2_vga),
        .phy_pipe_control_five(p2_phy)
    );

    // 214h image: base power, scale, pm state at 14:13
    assign PWR_BUDGET0_REGS[95:64] = {17'h0_0000, p2_pwr_lo};
    // 218h image: system allocated at bit 0
    assign PWR_BUDGET1_REGS[95:64] = {31'h0000_0000, p2_sys_alloc};
    // 74h image: pm fields 13:8, rx polarity disable at 14
    assign PM_CONTROL_REGS[95:64] = {17'h0_0000, p2_pm_ctl, 8'h00};
    // 70h image: vga decode at 31
    assign VGA_DECODE_REGS[95:64] = {p2_vga, 31'h0000_0000};
    // 88h image: phy byte at 31:24
    assign PHY_PIPE_CONTROL_FIVE_REGS[95:64] = {p2_phy, 24'h00_0000};

    // port 2 and port 1 slot register images: loaded bits in place, the rest zero
    // CCh image: logical port number at 26:24
    assign P2_PORTNUM_REG = {5'h00, portnum, 24'h00_0000};
    // 154h image: vc0 map at 7:1, bit 0 stays zero
    assign P2_VC0MAP_REG = {24'h00_0000, vc0map, 1'b0};
    // port 1 D4h image: low half loaded, high half zero here
    assign P1_SLOTCAP_REG = {16'h0000, slotlo};

    // loader sequencing
    // idle: no word seen yet; fields hold their defaults
    // load: words are arriving and being placed
    // done: end marker seen; fields frozen until reset
    // a word in the same cycle as the end marker still lands,
    // because the strobes look at the state before the edge
    always_comb
    begin
        // hold by default
        state_next = state_reg;
        case (state_reg)
            PCWL_IDLE:
                // an end marker with no words goes straight to done
                if (LOAD_END)
                    state_next = PCWL_DONE;
                else if (WORD_VALID)
                    state_next = PCWL_LOAD;
            PCWL_LOAD:
                // keep loading until the end marker
                if (LOAD_END)
                    state_next = PCWL_DONE;
            PCWL_DONE:
                // only reset leaves done
                state_next = PCWL_DONE;
            default:
                // unused code: fall back to idle
                state_next = PCWL_IDLE;
        endcase
    end

    // state register, cleared by the asynchronous reset
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
            state_reg <= PCWL_IDLE;
        else
            state_reg <= state_next;
    end

    // config accesses are served only once loading has ended,
    // so no reader ever sees a half-loaded register
    assign CFG_READY = (state_reg == PCWL_DONE);

endmodule : pcwl_loader

// ---- logic/pcwl_pkg.sv ----
// pcwl_pkg: word addresses, register offsets, reset values and loader states
// for the per-port configuration word loader.
// assumes: three ports, 16-bit words, 32-bit configuration registers.
package pcwl_pkg;
    // number of switch ports
    localparam int PCWL_PORTS = 3;
    // word addresses of the loaded words
    localparam logic [7:0] WA_PORTNUM_P2 = 8'h64;
    localparam logic [7:0] WA_PWR_P0 = 8'h70;
    localparam logic [7:0] WA_PWR_P1 = 8'h72;
    localparam logic [7:0] WA_PWR_P2 = 8'h74;
    localparam logic [7:0] WA_PMC_P0 = 8'h80;
    localparam logic [7:0] WA_PMC_P1 = 8'h82;
    localparam logic [7:0] WA_PMC_P2 = 8'h84;
    localparam logic [7:0] WA_SLOTLO_P1 = 8'h92;
    // configuration register offsets, kept for reference by the readers
    localparam logic [11:0] OFS_PORTNUM = 12'h0CC;
    localparam logic [11:0] OFS_VC0MAP = 12'h154;
    localparam logic [11:0] OFS_PWR0 = 12'h214;
    localparam logic [11:0] OFS_PWR1 = 12'h218;
    localparam logic [11:0] OFS_PMC = 12'h074;
    localparam logic [11:0] OFS_VGA = 12'h070;
    localparam logic [11:0] OFS_PHY5 = 12'h088;
    localparam logic [11:0] OFS_SLOTCAP = 12'h0D4;
    // reset values of the loaded fields
    localparam logic [2:0] RST_PORTNUM = 3'h2;
    localparam logic [6:0] RST_VC0MAP = 7'h7F;
    localparam logic [14:0] RST_PWR0 = 15'h0000;
    localparam logic RST_PWR1 = 1'b0;
    localparam logic [6:0] RST_PMC = 7'h00;
    localparam logic RST_VGA = 1'b0;
    localparam logic [7:0] RST_PHY5 = 8'h00;
    localparam logic [15:0] RST_SLOTLO = 16'h0000;
    // loader states
    typedef enum logic [1:0] {PCWL_IDLE, PCWL_LOAD, PCWL_DONE} pcwl_state_t;
endpackage : pcwl_pkg

// ---- logic/pcwl_field_reg.sv ----
// pcwl_field_reg: one loadable configuration field with a reset default.
// assumes: load is a single-cycle qualified strobe in the REF_CLK domain.
`timescale 1ns/1ns
module pcwl_field_reg
#(
    parameter int W = 8,
    parameter logic [W-1:0] INIT = '0
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [W-1:0] din,
    output logic [W-1:0] q
);
    // next value: the new word on a strobe, otherwise the held value
    wire logic [W-1:0] q_next = load ? din : q;
    // field keeps its default until a word names it; changes only on a load edge
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            q <= INIT;
        else
            q <= q_next;
    end
endmodule : pcwl_field_reg

// ---- logic/pcwl_port_fields.sv ----
// pcwl_port_fields: power budget, power control, vga and phy fields of one port.
// assumes: strobes are decoded by the loader top for this port only.
`timescale 1ns/1ns
module pcwl_port_fields
    import pcwl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pwr_load,
    input wire logic pmc_load,
    input wire logic [15:0] word,
    output logic [14:0] pwr_budget_lo,
    output logic pwr_sys_alloc,
    output logic [6:0] pm_control,
    output logic vga_enable,
    output logic [7:0] phy_pipe_control_five
);
    // power budget word rearranged into the low register layout
    wire logic [14:0] pwr_map = {word[11:10], 3'h0, word[9:8], word[7:0]};
    // low budget register: base power, data scale, pm state
    pcwl_field_reg #(.W(15), .INIT(RST_PWR0)) u_pwr0
    (
        .clk(clk),
        .rst_n(rst_n),
        .load(pwr_load),
        .din(pwr_map),
        .q(pwr_budget_lo)
    );
    // system allocated flag
    pcwl_field_reg #(.W(1), .INIT(RST_PWR1)) u_pwr1
    (
        .clk(clk),
        .rst_n(rst_n),
        .load(pwr_load),
        .din(word[15]),
        .q(pwr_sys_alloc)
    );
    // pm control: d3-to-l1, l1 delay, l0s enable, rx polarity disable
    pcwl_field_reg #(.W(7), .INIT(RST_PMC)) u_pmc
    (
        .clk(clk),
        .rst_n(rst_n),
        .load(pmc_load),
        .din(word[6:0]),
        .q(pm_control)
    );
    // vga decode enable
    pcwl_field_reg #(.W(1), .INIT(RST_VGA)) u_vga
    (
        .clk(clk),
        .rst_n(rst_n),
        .load(pmc_load),
        .din(word[7]),
        .q(vga_enable)
    );
    // vendor phy control byte
    pcwl_field_reg #(.W(8), .INIT(RST_PHY5)) u_phy
    (
        .clk(clk),
        .rst_n(rst_n),
        .load(pmc_load),
        .din(word[15:8]),
        .q(phy_pipe_control_five)
    );
endmodule : pcwl_port_fields

// ---- test/pcwl_loader_sva.sv ----
// pcwl_loader_sva: port-level checks of the configuration word loader.
// assumes: bound to pcwl_loader, one REF_CLK domain, RST_N async low.
`timescale 1ns/1ns
module pcwl_loader_sva
(
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic WORD_VALID,
    input wire logic [7:0] WORD_ADDR,
    input wire logic [15:0] WORD_DATA,
    input wire logic LOAD_END,
    input wire logic CFG_READY,
    input wire logic [31:0] P2_PORTNUM_REG,
    input wire logic [31:0] P2_VC0MAP_REG,
    input wire logic [95:0] PWR_BUDGET0_REGS,
    input wire logic [95:0] PWR_BUDGET1_REGS,
    input wire logic [95:0] PM_CONTROL_REGS,
    input wire logic [95:0] VGA_DECODE_REGS,
    input wire logic [95:0] PHY_PIPE_CONTROL_FIVE_REGS,
    input wire logic [31:0] P1_SLOTCAP_REG
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    // a word the loader must take this edge
    wire logic live = WORD_VALID && !CFG_READY;
    property p_portnum;
        live && WORD_ADDR == 8'h64 |=> P2_PORTNUM_REG[26:24] == $past(WORD_DATA[6:4]);
    endproperty
    a_portnum: assert property (p_portnum)
        else $error("logical port number not loaded");
    property p_vc0map;
        live && WORD_ADDR == 8'h64 |=> P2_VC0MAP_REG[7:1] == $past(WORD_DATA[15:9]);
    endproperty
    a_vc0map: assert property (p_vc0map)
        else $error("vc0 map not loaded");
    property p_pwr;
        live && WORD_ADDR == 8'h70 |=> PWR_BUDGET0_REGS[14:0]
            == {$past(WORD_DATA[11:10]), 3'h0, $past(WORD_DATA[9:0])};
    endproperty
    a_pwr: assert property (p_pwr)
        else $error("power budget word misplaced");
    property p_sysalloc;
        live && WORD_ADDR == 8'h74 |=> PWR_BUDGET1_REGS[64] == $past(WORD_DATA[15]);
    endproperty
    a_sysalloc: assert property (p_sysalloc)
        else $error("system allocated flag wrong");
    property p_pmc;
        live && WORD_ADDR == 8'h82 |=> PM_CONTROL_REGS[46:40] == $past(WORD_DATA[6:0]);
    endproperty
    a_pmc: assert property (p_pmc)
        else $error("power control fields wrong");
    property p_vga;
        live && WORD_ADDR == 8'h84 |=> VGA_DECODE_REGS[95] == $past(WORD_DATA[7]);
    endproperty
    a_vga: assert property (p_vga)
        else $error("vga decode enable wrong");
    property p_phy;
        live && WORD_ADDR == 8'h80 |=> PHY_PIPE_CONTROL_FIVE_REGS[31:24] == $past(WORD_DATA[15:8]);
    endproperty
    a_phy: assert property (p_phy)
        else $error("phy control byte wrong");
    property p_slot;
        live && WORD_ADDR == 8'h92 |=> P1_SLOTCAP_REG == {16'h0000, $past(WORD_DATA)};
    endproperty
    a_slot: assert property (p_slot)
        else $error("slot capability low word wrong");
    // once served, readiness holds and the slot and 214h power budget images freeze
    property p_frozen;
        CFG_READY |=> CFG_READY && $stable(P1_SLOTCAP_REG) && $stable(PWR_BUDGET0_REGS);
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("fields changed after ready");
    property p_early;
        !CFG_READY && !LOAD_END |=> !CFG_READY;
    endproperty
    a_early: assert property (p_early)
        else $error("ready before load end");
    c_slot: cover property (live && WORD_ADDR == 8'h92);
    c_ready: cover property ($rose(CFG_READY));
    c_late: cover property (WORD_VALID && CFG_READY);
endmodule : pcwl_loader_sva
bind pcwl_loader pcwl_loader_sva i_sva (.REF_CLK(REF_CLK), .RST_N(RST_N),
    .WORD_VALID(WORD_VALID), .WORD_ADDR(WORD_ADDR), .WORD_DATA(WORD_DATA),
    .LOAD_END(LOAD_END), .CFG_READY(CFG_READY), .P2_PORTNUM_REG(P2_PORTNUM_REG),
    .P2_VC0MAP_REG(P2_VC0MAP_REG), .PWR_BUDGET0_REGS(PWR_BUDGET0_REGS),
    .PWR_BUDGET1_REGS(PWR_BUDGET1_REGS), .PM_CONTROL_REGS(PM_CONTROL_REGS),
    .VGA_DECODE_REGS(VGA_DECODE_REGS), .P1_SLOTCAP_REG(P1_SLOTCAP_REG),
    .PHY_PIPE_CONTROL_FIVE_REGS(PHY_PIPE_CONTROL_FIVE_REGS));

// ---- test/pcwl_word_source.sv ----
// pcwl_word_source: behavioural configuration word source.
// assumes: bench calls its tasks; drives only at falling edges.
`timescale 1ns/1ns
module pcwl_word_source
(
    input wire logic clk,
    output logic word_valid,
    output logic [7:0] word_addr,
    output logic [15:0] word_data,
    output logic load_end
);
    initial
    begin
        word_valid = 1'b0;
        word_addr = 8'h00;
        word_data = 16'h0000;
        load_end = 1'b0;
    end
    // present a word; stays up so calls run back to back
    task automatic send(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        word_valid = 1'b1;
        word_addr = a;
        word_data = d;
    endtask : send
    // release the bus; stale lines are inverted, not held
    task automatic idle();
        @(negedge clk);
        word_valid = 1'b0;
        load_end = 1'b0;
        word_addr = ~word_addr;
        word_data = ~word_data;
    endtask : idle
    // raise the end marker; it stays up until idle clears it
    task automatic finish();
        @(negedge clk);
        load_end = 1'b1;
    endtask : finish
endmodule : pcwl_word_source

// ---- test/pcwl_loader_bench.sv ----
// pcwl_loader_bench: self-checking bench of the word loader.
// assumes: word source model drives the load side.
`timescale 1ns/1ns
module pcwl_loader_bench
    import pcwl_pkg::*;
;
    logic REF_CLK = 1'b0;
    logic RST_N = 1'b0;
    logic WORD_VALID, LOAD_END, CFG_READY;
    logic [7:0] WORD_ADDR;
    logic [15:0] WORD_DATA;
    logic [31:0] P2_PORTNUM_REG, P2_VC0MAP_REG, P1_SLOTCAP_REG;
    logic [95:0] PWR_BUDGET0_REGS, PWR_BUDGET1_REGS, PM_CONTROL_REGS;
    logic [95:0] VGA_DECODE_REGS, PHY_PIPE_CONTROL_FIVE_REGS;
    int err_count = 0;
    int compares = 0;
    logic [15:0] pw [3] = '{16'h8D12, 16'h7BEF, 16'hF3A5};
    logic [15:0] pc [3] = '{16'hA5C3, 16'h3A7E, 16'h5F01};
    always #5 REF_CLK = ~REF_CLK;
    pcwl_word_source i_src (.clk(REF_CLK), .word_valid(WORD_VALID), .word_addr(WORD_ADDR),
        .word_data(WORD_DATA), .load_end(LOAD_END));
    pcwl_loader i_dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .WORD_VALID(WORD_VALID),
        .WORD_ADDR(WORD_ADDR), .WORD_DATA(WORD_DATA), .LOAD_END(LOAD_END),
        .CFG_READY(CFG_READY), .P2_PORTNUM_REG(P2_PORTNUM_REG), .P2_VC0MAP_REG(P2_VC0MAP_REG),
        .PWR_BUDGET0_REGS(PWR_BUDGET0_REGS), .PWR_BUDGET1_REGS(PWR_BUDGET1_REGS),
        .PM_CONTROL_REGS(PM_CONTROL_REGS), .VGA_DECODE_REGS(VGA_DECODE_REGS),
        .PHY_PIPE_CONTROL_FIVE_REGS(PHY_PIPE_CONTROL_FIVE_REGS), .P1_SLOTCAP_REG(P1_SLOTCAP_REG));
    // compare one value, report and count a mismatch
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic final_report();
        if (err_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report
    // reset held for 16 cycles, then defaults checked
    task automatic t_reset();
        RST_N = 1'b0;
        repeat (16) @(negedge REF_CLK);
        check("ready", {31'h0000_0000, CFG_READY}, 32'h0000_0000);
        check("portnum", P2_PORTNUM_REG, {5'h00, RST_PORTNUM, 24'h00_0000});
        check("vc0map", P2_VC0MAP_REG, {24'h00_0000, RST_VC0MAP, 1'h0});
        check("slot", P1_SLOTCAP_REG, 32'h0000_0000);
        check("pwr", PWR_BUDGET0_REGS[31:0] | PM_CONTROL_REGS[63:32], 32'h0000_0000);
        RST_N = 1'b1;
    endtask : t_reset
    // three power budget words back to back
    task automatic t_pwr();
        for (int p = 0; p < 3; p++)
            i_src.send(8'h70 + 8'(2 * p), pw[p]);
        i_src.idle();
        for (int p = 0; p < 3; p++)
        begin
            check("pwr0", PWR_BUDGET0_REGS[p*32+:32],
                {17'h0_0000, pw[p][11:10], 3'h0, pw[p][9:0]});
            check("pwr1", PWR_BUDGET1_REGS[p*32+:32], {31'h0000_0000, pw[p][15]});
        end
    endtask : t_pwr
    // three power control words: pm, vga and phy fields
    task automatic t_pmc();
        for (int p = 0; p < 3; p++)
            i_src.send(8'h80 + 8'(2 * p), pc[p]);
        i_src.idle();
        for (int p = 0; p < 3; p++)
        begin
            check("pmc", PM_CONTROL_REGS[p*32+:32], {17'h0_0000, pc[p][6:0], 8'h00});
            check("vga", VGA_DECODE_REGS[p*32+:32], {pc[p][7], 31'h0000_0000});
            check("phy", PHY_PIPE_CONTROL_FIVE_REGS[p*32+:32], {pc[p][15:8], 24'h00_0000});
        end
    endtask : t_pmc
    // port 2 word, slot twice (last wins), unmapped address ignored
    task automatic t_misc();
        i_src.send(8'h64, 16'hB4D5);
        i_src.send(8'h92, 16'h1234);
        i_src.send(8'h92, 16'hC0DE);
        i_src.send(8'h66, 16'hFFFF);
        i_src.idle();
        check("portnum", P2_PORTNUM_REG, 32'h0500_0000);
        check("vc0map", P2_VC0MAP_REG, 32'h0000_00B4);
        check("slot", P1_SLOTCAP_REG, 32'h0000_C0DE);
    endtask : t_misc
    // load end, then late words refused
    task automatic t_done();
        i_src.finish();
        i_src.idle();
        i_src.send(8'h92, 16'hFFFF);
        i_src.send(8'h70, 16'h0000);
        i_src.idle();
        check("ready", {31'h0000_0000, CFG_READY}, 32'h0000_0001);
        check("slot", P1_SLOTCAP_REG, 32'h0000_C0DE);
        check("pwr0", PWR_BUDGET0_REGS[31:0], 32'h0000_6112);
    endtask : t_done
    initial
    begin
        t_reset();
        t_pwr();
        t_pmc();
        t_misc();
        t_done();
        t_reset();
        final_report();
    end
    // run needs about 50 cycles; allow far more
    initial
    begin
        #50000;
        err_count++;
        final_report();
    end
endmodule : pcwl_loader_bench
